// file: twms_engine.sv
// Two-wire master status engine with an AHB-Lite register slave.
// Assumes open-drain scl/sda pads resolved outside; pins are async.
//
// Behaviour
// - Address-write not acked reports 0x20
// - Data sent reports 0x28 or 0x30
// - Stop request clears itself after STOP
// - Start plus stop gives STOP then START
// - Lost arbitration reports 0x38, release or restart
// - Address direction bit selects transmit or receive
// - START generated once bus seen idle
// - After START flag set, status 0x08
// - Address-read reports 0x38, 0x40 or 0x48
// - Received byte valid while flag set
// - Repeated START reports 0x10
// - Bus kept owned after repeated START
// - Prescaler bits separate from status code
// - Control register bit layout fixed
// - Transfer suspended while flag set
// - Data write with flag low collides
`default_nettype none

module twms_engine #(
  parameter int unsigned HALF_CYC = twms_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Two-wire pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // Interrupt
  output logic             irq_out
);

  // ******************************
  // State
  // ******************************
  typedef struct packed {
    twms_pkg::twms_state_e state;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [7:0]  data;
    logic [7:0]  code;
    logic [1:0]  presc;
    logic        flag;
    logic        ack_en;
    logic        sta;
    logic        sto;
    logic        wcol;
    logic        en;
    logic        ie;
    logic        rx;
    logic        addr;
    logic        rs;
    logic        own;
    logic        busy;
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic        scl_q;
    logic        sda_q;
    logic        scl_low;
    logic        sda_low;
    logic        ap_valid;
    logic        ap_write;
    logic [1:0]  ap_sel;
    logic [31:0] hrdata;
    logic        hready;
    logic        pin_lvl;
    logic        irq;
  } twms_regs_s;

  twms_regs_s r;
  twms_regs_s next_r;

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [1:0] reg_sel(
    input logic [11:0] a
  );
    logic [1:0] s;
    s = twms_pkg::SEL_NONE;
    if (a == twms_pkg::CTL_OFF) s = twms_pkg::SEL_CTL;
    if (a == twms_pkg::STS_OFF) s = twms_pkg::SEL_STS;
    if (a == twms_pkg::DAT_OFF) s = twms_pkg::SEL_DAT;
    return s;
  endfunction

  // Level we pull SDA to for bit n: data bits or our ack
  function automatic logic pull_low(
    input logic       rx,
    input logic [3:0] n,
    input logic       d7,
    input logic       ack
  );
    return rx ? (n == 4'h8 && ack) : (n != 4'h8 && !d7);
  endfunction

  logic       scl_s;
  logic       sda_s;
  logic       tick;
  logic       go;
  logic       ack;
  logic [7:0] wr;
  logic [7:0] ctl_rd;
  logic [7:0] sts_rd;

  assign scl_s = r.scl_sy[1];
  assign sda_s = r.sda_sy[1];
  assign tick  = r.cnt == 16'(HALF_CYC - 1);
  assign wr    = hwdata_in[7:0];
  assign ctl_rd = {r.flag, r.ack_en, r.sta, r.sto,
                   r.wcol, r.en, 1'b0, r.ie};
  assign sts_rd = {r.code[7:3], 1'b0, r.presc};

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    next_r = r;
    go     = 1'b0;
    ack    = !sda_s;

    // Pin synchronisers and bus idle tracking
    next_r.scl_sy = {r.scl_sy[0], scl_in};
    next_r.sda_sy = {r.sda_sy[0], sda_in};
    next_r.scl_q  = scl_s;
    next_r.sda_q  = sda_s;
    if (scl_s && r.scl_q && r.sda_q && !sda_s) begin
      next_r.busy = 1'b1;
    end else if (scl_s && r.scl_q && !r.sda_q && sda_s) begin
      next_r.busy = 1'b0;
    end

    // Bus address phase; read data ready for data phase
    next_r.hready   = 1'b1;
    next_r.pin_lvl  = 1'b0;
    next_r.ap_valid = hsel_in & htrans_in[1] & hready_in
                      & (hsize_in == 3'h2);
    next_r.ap_write = hwrite_in;
    next_r.ap_sel   = reg_sel(haddr_in[11:0]);
    case (reg_sel(haddr_in[11:0]))
      twms_pkg::SEL_CTL: next_r.hrdata = {24'h0, ctl_rd};
      twms_pkg::SEL_STS: next_r.hrdata = {24'h0, sts_rd};
      twms_pkg::SEL_DAT: next_r.hrdata = {24'h0, r.data};
      default:           next_r.hrdata = 32'h0;
    endcase

    // Bus data phase writes
    if (r.ap_valid && r.ap_write) begin
      case (r.ap_sel)
        twms_pkg::SEL_CTL: begin
          next_r.ack_en = wr[twms_pkg::ACK_BIT];
          next_r.sta    = wr[twms_pkg::STA_BIT];
          next_r.sto    = wr[twms_pkg::STO_BIT];
          next_r.en     = wr[twms_pkg::EN_BIT];
          next_r.ie     = wr[twms_pkg::IE_BIT];
          if (wr[twms_pkg::FLAG_BIT]) next_r.flag = 1'b0;
          go = wr[twms_pkg::FLAG_BIT] & wr[twms_pkg::EN_BIT];
        end
        twms_pkg::SEL_STS: next_r.presc = wr[1:0];
        twms_pkg::SEL_DAT: begin
          if (r.flag) begin
            next_r.data = wr;
            next_r.wcol = 1'b0;
          end else begin
            next_r.wcol = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Engine; half-period timer runs freely between events
    next_r.cnt = tick ? 16'h0 : r.cnt + 16'h1;
    if (!next_r.en) begin
      next_r.state   = twms_pkg::S_IDLE;
      next_r.scl_low = 1'b0;
      next_r.sda_low = 1'b0;
      next_r.own     = 1'b0;
    end else begin
      unique case (r.state)
        twms_pkg::S_IDLE, twms_pkg::S_HOLD: begin
          if (go) begin
            next_r.cnt = 16'h0;
            if (!r.own) begin
              next_r.code  = twms_pkg::ST_NONE;
              next_r.state = next_r.sta ? twms_pkg::S_WAIT
                                        : twms_pkg::S_IDLE;
            end else if (next_r.sto) begin
              next_r.state   = twms_pkg::S_STOP_A;
              next_r.sda_low = 1'b1;
            end else if (next_r.sta) begin
              // restart without giving up the bus
              next_r.state   = twms_pkg::S_RS_A;
              next_r.sda_low = 1'b0;
            end else begin
              next_r.state = twms_pkg::S_LOW;
              next_r.bitn  = 4'h0;
              if (r.addr) next_r.rx = next_r.data[0];
              // Address byte is always sent, even for a read
              next_r.sda_low = pull_low(next_r.rx && !r.addr, 4'h0,
                                        next_r.data[7],
                                        next_r.ack_en);
            end
          end
        end
        twms_pkg::S_WAIT: begin
          if (!r.busy) begin
            next_r.state   = twms_pkg::S_START;
            next_r.sda_low = 1'b1;
            next_r.own     = 1'b1;
            next_r.rs      = 1'b0;
            next_r.cnt     = 16'h0;
          end
        end
        twms_pkg::S_START: begin
          if (tick) begin
            next_r.scl_low = 1'b1;
            next_r.state   = twms_pkg::S_HOLD;
            next_r.flag    = 1'b1;
            next_r.addr    = 1'b1;
            next_r.code    = r.rs ? twms_pkg::ST_RSTART
                                  : twms_pkg::ST_START;
          end
        end
        twms_pkg::S_LOW: begin
          if (tick) begin
            next_r.state   = twms_pkg::S_HIGH;
            next_r.scl_low = 1'b0;
          end
        end
        twms_pkg::S_HIGH: begin
          // Slow slaves may hold the clock low
          if (!scl_s) begin
            next_r.cnt = 16'h0;
          end else if (tick) begin
            if (!r.sda_low && !sda_s &&
                (r.rx && !r.addr ? r.bitn == 4'h8 : r.bitn != 4'h8)) begin
              next_r.state   = twms_pkg::S_HOLD;
              next_r.flag    = 1'b1;
              next_r.code    = twms_pkg::ST_LOST;
              next_r.own     = 1'b0;
              next_r.scl_low = 1'b0;
              next_r.sda_low = 1'b0;
              next_r.addr    = 1'b0;
            end else if (r.bitn != 4'h8) begin
              next_r.data    = {r.data[6:0], sda_s};
              next_r.bitn    = r.bitn + 4'h1;
              next_r.scl_low = 1'b1;
              next_r.state   = twms_pkg::S_LOW;
              next_r.sda_low = pull_low(r.rx && !r.addr, next_r.bitn,
                                        r.data[6], r.ack_en);
            end else begin
              next_r.state   = twms_pkg::S_HOLD;
              next_r.flag    = 1'b1;
              next_r.scl_low = 1'b1;
              next_r.sda_low = 1'b0;
              next_r.addr    = 1'b0;
              if (r.addr && !r.rx) begin
                next_r.code = ack ? twms_pkg::ST_AW_ACK
                                  : twms_pkg::ST_AW_NAK;
              end else if (r.addr) begin
                next_r.code = ack ? twms_pkg::ST_AR_ACK
                                  : twms_pkg::ST_AR_NAK;
              end else if (!r.rx) begin
                next_r.code = ack ? twms_pkg::ST_TX_ACK
                                  : twms_pkg::ST_TX_NAK;
              end else begin
                next_r.code = ack ? twms_pkg::ST_RX_ACK
                                  : twms_pkg::ST_RX_NAK;
              end
            end
          end
        end
        twms_pkg::S_RS_A: begin
          if (tick) begin
            next_r.state   = twms_pkg::S_RS_B;
            next_r.scl_low = 1'b0;
          end
        end
        twms_pkg::S_RS_B: begin
          if (!scl_s) begin
            next_r.cnt = 16'h0;
          end else if (tick) begin
            next_r.state   = twms_pkg::S_START;
            next_r.sda_low = 1'b1;
            next_r.rs      = 1'b1;
          end
        end
        twms_pkg::S_STOP_A: begin
          if (tick) begin
            next_r.state   = twms_pkg::S_STOP_B;
            next_r.scl_low = 1'b0;
          end
        end
        twms_pkg::S_STOP_B: begin
          if (!scl_s) begin
            next_r.cnt = 16'h0;
          end else if (tick) begin
            next_r.state   = twms_pkg::S_STOP_C;
            next_r.sda_low = 1'b0;
          end
        end
        twms_pkg::S_STOP_C: begin
          if (tick) begin
            next_r.sto   = 1'b0;
            next_r.own   = 1'b0;
            next_r.code  = twms_pkg::ST_NONE;
            next_r.state = next_r.sta ? twms_pkg::S_WAIT
                                      : twms_pkg::S_IDLE;
          end
        end
      endcase
    end

    next_r.irq = next_r.flag & next_r.ie;
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      r        <= '0;
      r.code   <= twms_pkg::STS_RST;
      r.data   <= twms_pkg::DAT_RST;
      r.scl_sy <= 2'b11;
      r.sda_sy <= 2'b11;
      r.scl_q  <= 1'b1;
      r.sda_q  <= 1'b1;
      r.hready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign hrdata_out    = r.hrdata;
  assign hreadyout_out = r.hready;
  assign hresp_out     = r.pin_lvl;
  assign scl_out       = r.pin_lvl;
  assign sda_out       = r.pin_lvl;
  assign scl_oe_n_out  = !r.scl_low;
  assign sda_oe_n_out  = !r.sda_low;
  assign irq_out       = r.irq;

endmodule

`default_nettype wire

// file: twms_engine_properties.sv
// Checker for the two-wire master engine, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module twms_engine_props #(
  parameter int unsigned HALF_CYC = 4
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Register bus
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_out,
  input  wire logic        hresp_out,
  // Pins and interrupt
  input  wire logic        scl_oe_n_out,
  input  wire logic        sda_in,
  input  wire logic        scl_in,
  input  wire logic        sda_oe_n_out,
  input  wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic        wr_q;
  logic [15:0] lo_cnt;

  // ****************************************
  // Helper logic
  // ****************************************
  // Data phase of a control write, so hwdata can be seen
  always_ff @(posedge clk_in) begin
    wr_q   <= !sys_rst_in && hsel_in && htrans_in[1] && hready_in && hwrite_in
              && hsize_in == 3'h2 && haddr_in[11:0] == twms_pkg::CTL_OFF;
    lo_cnt <= (sys_rst_in || scl_oe_n_out) ? 16'h0 : lo_cnt + 16'h1;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_irq_clear: assert property (wr_q && hwdata_in[7] |-> ##2 !irq_out)
    else $error("interrupt survives a flag clear");
  a_irq_mask: assert property (wr_q && !hwdata_in[0] |-> ##2 !irq_out [*3])
    else $error("interrupt high while disabled");
  a_hold_pins: assert property (irq_out && $past(irq_out) && !$past(wr_q)
    |-> $stable(scl_oe_n_out) && $stable(sda_oe_n_out))
    else $error("pins moved while step held");
  a_flag_pins: assert property ($rose(irq_out) |-> !scl_oe_n_out || sda_oe_n_out && scl_oe_n_out)
    else $error("flag raised with clock running");
  // Sync delay is three samples, so the bus must look idle then
  a_start_idle: assert property ($fell(sda_oe_n_out) && scl_oe_n_out
    |-> $past(sda_in, 3) && $past(scl_in, 3) ##1 scl_oe_n_out [*3])
    else $error("start while bus busy");
  a_stop_gap: assert property ($rose(sda_oe_n_out) && scl_oe_n_out && $past(scl_oe_n_out)
    |-> sda_oe_n_out [*2])
    else $error("start glued to stop");
  a_scl_low: assert property ($rose(scl_oe_n_out) |-> lo_cnt >= HALF_CYC)
    else $error("clock low phase too short");
  a_byte_width: assert property (hrdata_out[31:8] == 24'h0 && hresp_out == 1'b0)
    else $error("read data wider than a byte");

  c_start: cover property ($fell(sda_oe_n_out) && scl_oe_n_out);
  c_flag: cover property ($rose(irq_out));
  c_stop: cover property ($rose(sda_oe_n_out) && scl_oe_n_out && $past(scl_oe_n_out));
endmodule

bind twms_engine twms_engine_props #(.HALF_CYC(HALF_CYC)) twms_engine_props_inst (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hresp_out(hresp_out),
  .scl_oe_n_out(scl_oe_n_out), .sda_in(sda_in), .scl_in(scl_in),
  .sda_oe_n_out(sda_oe_n_out), .irq_out(irq_out));

`default_nettype wire

// file: twms_engine_tb.sv
// Self-checking bench for the two-wire master engine.
// Assumes the slave model and bound checker are compiled first.
`default_nettype none

module twms_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] ctl_a = twms_pkg::CTL_OFF;
  localparam logic [11:0] sts_a = twms_pkg::STS_OFF;
  localparam logic [11:0] dat_a = twms_pkg::DAT_OFF;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        scl_oe_n, sda_oe_n, scl_o, sda_o, irq, sda_n;
  logic        ack = 1'b1;
  logic        arb = 1'b0;
  logic [7:0]  tx = 8'h96;
  logic [7:0]  rx;
  logic [7:0]  rdat;
  int          fail_count = 0;
  int          checked = 0;
  // Open-drain wires; arb is a rival master holding data low
  wire         scl = scl_oe_n | scl_o;
  wire         sda = (sda_oe_n | sda_o) & sda_n & !arb;

  always #12.5 clk = ~clk;

  twms_engine #(.HALF_CYC(6)) twms_engine_inst (
    .clk_in(clk), .sys_rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(), .scl_in(scl), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .irq_out(irq));
  twms_slave twms_slave_inst (.scl_in(scl), .sda_in(sda), .ack_en_in(ack), .tx_in(tx),
    .sda_n_out(sda_n), .rx_out(rx));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      fail_count++;
      conclude;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdy;
    rdat = hrdata[7:0];
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    chk(rdat, e);
  endtask
  task automatic wbit(input int b, input logic v);
    for (int n = 0; n < 500; n++) begin
      bus(1'b0, ctl_a, 8'h0);
      if (rdat[b] === v) return;
    end
    fail_count++;
    conclude;
  endtask
  task automatic step(input logic [7:0] d, input logic [7:0] c, input logic [7:0] s);
    bus(1'b1, dat_a, d);
    bus(1'b1, ctl_a, c);
    wbit(7, 1'b1);
    rc(sts_a, s);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(ctl_a, 8'h00);
    rc(sts_a, 8'hf8);
    rc(dat_a, 8'hff);
    rc(12'h00c, 8'h00);
    bus(1'b1, sts_a, 8'h03);
    rc(sts_a, 8'hfb);
    bus(1'b1, sts_a, 8'h00);
    bus(1'b1, ctl_a, 8'h04);
    bus(1'b1, dat_a, 8'h11);
    rc(ctl_a, 8'h0c);
    rc(dat_a, 8'hff);
    $display("test registers done");
    bus(1'b1, ctl_a, 8'ha5);
    wbit(7, 1'b1);
    rc(sts_a, twms_pkg::ST_START);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, scl_oe_n}, 8'h00);
    ack <= 1'b0;
    step(8'ha0, 8'h85, twms_pkg::ST_AW_NAK);
    step(8'h5a, 8'h85, twms_pkg::ST_TX_NAK);
    ack <= 1'b1;
    step(8'h3c, 8'h85, twms_pkg::ST_TX_ACK);
    chk(rx, 8'h3c);
    step(8'h3c, 8'ha5, twms_pkg::ST_RSTART);
    step(8'ha1, 8'h85, twms_pkg::ST_AR_ACK);
    chk({7'h0, scl_oe_n}, 8'h00);
    step(8'h00, 8'hc5, twms_pkg::ST_RX_ACK);
    rc(dat_a, 8'h96);
    tx <= 8'ha5;
    step(8'h00, 8'h85, twms_pkg::ST_RX_NAK);
    rc(dat_a, 8'ha5);
    step(8'h00, 8'hb5, twms_pkg::ST_START);
    bus(1'b0, ctl_a, 8'h0);
    chk(rdat & 8'h10, 8'h00);
    ack <= 1'b0;
    step(8'ha1, 8'h85, twms_pkg::ST_AR_NAK);
    bus(1'b1, ctl_a, 8'h95);
    wbit(4, 1'b0);
    chk(rdat & 8'h80, 8'h00);
    rc(sts_a, twms_pkg::ST_NONE);
    $display("test transfers done");
    ack <= 1'b1;
    bus(1'b1, ctl_a, 8'ha5);
    wbit(7, 1'b1);
    arb <= 1'b1;
    step(8'h81, 8'h85, twms_pkg::ST_LOST);
    chk({scl_oe_n, sda_oe_n, 6'h0}, 8'hc0);
    bus(1'b1, ctl_a, 8'ha4);
    repeat (60) @(posedge clk);
    bus(1'b0, ctl_a, 8'h0);
    chk(rdat & 8'h80, 8'h00);
    arb <= 1'b0;
    wbit(7, 1'b1);
    rc(sts_a, twms_pkg::ST_START);
    chk({7'h0, irq}, 8'h00);
    bus(1'b1, ctl_a, 8'h94);
    wbit(4, 1'b0);
    $display("test arbitration done");
    conclude;
  end
endmodule

`default_nettype wire

// file: twms_pkg.sv
// Constants and types of the two-wire master engine.
// Assumes a 40 MHz system clock and an AHB-Lite register bus.
`default_nettype none

package twms_pkg;

  // ******************************
  // Register map and fields
  // ******************************
  localparam logic [11:0] CTL_OFF = 12'h000;
  localparam logic [11:0] STS_OFF = 12'h004;
  localparam logic [11:0] DAT_OFF = 12'h008;

  localparam logic [1:0] SEL_CTL  = 2'h0;
  localparam logic [1:0] SEL_STS  = 2'h1;
  localparam logic [1:0] SEL_DAT  = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT  = 6;
  localparam int STA_BIT  = 5;
  localparam int STO_BIT  = 4;
  localparam int WCOL_BIT = 3;
  localparam int EN_BIT   = 2;
  localparam int IE_BIT   = 0;

  localparam logic [7:0] STS_RST = 8'hf8;
  localparam logic [7:0] DAT_RST = 8'hff;

  // ******************************
  // Status codes
  // ******************************
  localparam logic [7:0] ST_START  = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NAK = 8'h20;
  localparam logic [7:0] ST_TX_ACK = 8'h28;
  localparam logic [7:0] ST_TX_NAK = 8'h30;
  localparam logic [7:0] ST_LOST   = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NAK = 8'h48;
  localparam logic [7:0] ST_RX_ACK = 8'h50;
  localparam logic [7:0] ST_RX_NAK = 8'h58;
  localparam logic [7:0] ST_NONE   = 8'hf8;

  // ******************************
  // Timing
  // ******************************
  localparam int CLK_NS      = 25;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC =
    (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    S_IDLE, S_HOLD, S_WAIT, S_START, S_LOW, S_HIGH,
    S_RS_A, S_RS_B, S_STOP_A, S_STOP_B, S_STOP_C
  } twms_state_e;

endpackage

`default_nettype wire

// file: twms_slave.sv
// Behavioural remote slave on the two-wire bus.
// Assumes pull-ups on both wires; never stretches the clock.
`default_nettype none

module twms_slave (
  // Bus wires
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // Behaviour
  input  wire logic       ack_en_in,
  input  wire logic [7:0] tx_in,
  output logic            sda_n_out,
  output logic      [7:0] rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  int         cnt;
  logic       rd;
  logic       adr;
  logic       nak;

  initial begin
    sda_n_out = 1'b1;
    rx_out = 8'h0;
    cnt = 0;
    rd = 1'b0;
    adr = 1'b0;
    nak = 1'b1;
  end

  // ****************************************
  // Frame tracking
  // ****************************************
  always @(negedge sda_in) if (scl_in) begin
    cnt = 0;
    adr = 1'b1;
    rd = 1'b0;
  end
  always @(posedge sda_in) if (scl_in) begin
    adr = 1'b0;
    rd = 1'b0;
  end
  always @(posedge scl_in) begin
    if (cnt < 8) sh = {sh[6:0], sda_in};
    else nak = sda_in;
    cnt = cnt + 1;
  end
  // Line changes only while the clock is low
  always @(negedge scl_in) begin
    if (cnt == 8) begin
      if (adr) rd = sh[0];
      else if (!rd) rx_out = sh;
      sda_n_out = (rd && !adr) ? 1'b1 : !ack_en_in;
    end else if (cnt == 9) begin
      cnt = 0;
      adr = 1'b0;
      // A refused byte ends sending so the master can stop
      sda_n_out = (rd && !nak) ? tx_in[7] : 1'b1;
    end else if (rd && !adr && cnt > 0) begin
      sda_n_out = tx_in[7 - cnt];
    end else begin
      sda_n_out = 1'b1;
    end
  end
endmodule

`default_nettype wire
